// file: rtl/utp_pkg.sv
package utp_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_MODE = 8'h08;
	localparam logic [7:0] IDX_PHASE = 8'h09;
	localparam logic [7:0] IDX_CTRL = 8'h0d;
	localparam logic [7:0] IDX_STAT = 8'h0e;
	localparam int ADDR_W = 10;
	// Serial mode register fields
	localparam int MODE_FEDE = 0;
	localparam int MODE_MULT = 1;
	localparam int MODE_ESI = 2;
	localparam int MODE_OFS = 6;
	localparam int MODE_EN = 7;
	localparam logic [7:0] MODE_KEEP = 8'hc7;
	// Control register fields
	localparam int CTRL_MODE_LO = 0;
	localparam int CTRL_SYNC_FAST = 2;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] PHASE_RST = 16'h0000;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// Bit period divisors
	localparam logic [5:0] DIV_BAUD_SLOW = 6'h3f;
	localparam logic [5:0] DIV_BAUD_FAST = 6'h0f;
	localparam logic [5:0] DIV_SYS_SLOW = 6'h3f;
	localparam logic [5:0] DIV_SYS_FAST = 6'h1f;
	localparam logic [5:0] DIV_SYNC_SLOW = 6'h0b;
	localparam logic [5:0] DIV_SYNC_FAST = 6'h03;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		UTP_SYNC,
		UTP_ASYNC_BAUD,
		UTP_ASYNC_SYS,
		UTP_ASYNC_BAUD_MP
	} utp_mode_e;

	typedef struct packed {
		logic mod_en;
		logic ofs;
		logic [2:0] rsvd;
		logic esi;
		logic mult;
		logic fede;
	} utp_smr_s;

	typedef struct packed {
		logic sync_fast;
		utp_mode_e mode;
	} utp_ctrl_s;
endpackage : utp_pkg

// file: rtl/utp_txd_mod.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
// Behaviour
// - With modulation enabled in modes 1, 2 or 3 the transmit pin carries the function picked by the select bit.
// - In mode 0 the enable bit is ignored and no combined output ever reaches the pin.
// - With the enable bit clear the select bit is ignored and the pin follows the plain UART transmit signal.
// - The 16-bit phase register sets the serial port 0 baud rate in modes 1 and 3.
// - Software writes the phase register and reads back all 16 bits freely.
// - Every reset clears the phase register to zero.
// - Select 0 gives NOR of transmit signal and timer waveform, select 1 gives their OR.
// - Modes 1 and 3 time bits from the baud clock divided by 64, or by 16 when the multiplier bit is set.
module utp_txd_mod (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [utp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [utp_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic uart_tx_signal,
	input wire logic timer_low_byte_waveform,
	output logic bit_tick,
	output logic uart0_transmit_pin
);
	utp_pkg::utp_smr_s smr, next_smr;
	utp_pkg::utp_ctrl_s ctrl, next_ctrl;
	logic [15:0] phase, next_phase;
	logic [16:0] acc, next_acc;
	logic [5:0] div_cnt, next_div_cnt;
	logic pin, next_pin;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [utp_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic do_write, baud_en, mod_active;
	logic [7:0] wr_idx, rd_idx;
	logic [5:0] div_top;

	// Handshakes
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign bit_tick = div_cnt == div_top && (ctrl.mode == utp_pkg::UTP_ASYNC_SYS
		|| ctrl.mode == utp_pkg::UTP_SYNC || baud_en);
	assign uart0_transmit_pin = pin;
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_idx = 8'(aw_addr[utp_pkg::ADDR_W-1:2]);
	assign rd_idx = 8'(s_axi_araddr[utp_pkg::ADDR_W-1:2]);

	// Write channel capture, register update and response
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_smr = smr;
		next_phase = phase;
		next_ctrl = ctrl;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = utp_pkg::RESP_OKAY;
			case (wr_idx)
				utp_pkg::IDX_MODE: begin
					if (w_strb[0]) begin
						next_smr = utp_pkg::utp_smr_s'(w_data[7:0] & utp_pkg::MODE_KEEP);
					end
				end
				utp_pkg::IDX_PHASE: begin
					if (w_strb[0]) begin
						next_phase[7:0] = w_data[7:0];
					end
					if (w_strb[1]) begin
						next_phase[15:8] = w_data[15:8];
					end
				end
				utp_pkg::IDX_CTRL: begin
					if (w_strb[0]) begin
						next_ctrl = utp_pkg::utp_ctrl_s'(w_data[2:0]);
					end
				end
				utp_pkg::IDX_STAT: begin
					next_bresp = utp_pkg::RESP_OKAY;
				end
				default: begin
					next_bresp = utp_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Read channel
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = utp_pkg::RESP_OKAY;
			case (rd_idx)
				utp_pkg::IDX_MODE: next_rdata = {24'h000000, smr};
				utp_pkg::IDX_PHASE: next_rdata = {16'h0000, phase};
				utp_pkg::IDX_CTRL: next_rdata = {29'h0, ctrl};
				utp_pkg::IDX_STAT: next_rdata = {24'h000000, div_cnt, mod_active, pin};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = utp_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Phase accumulator: its carry is the baud clock
	always_comb begin
		next_acc = {1'b0, acc[15:0]} + {1'b0, phase};
		baud_en = acc[16];
	end

	// Bit period divider
	always_comb begin
		case (ctrl.mode)
			utp_pkg::UTP_SYNC: div_top = ctrl.sync_fast ? utp_pkg::DIV_SYNC_FAST : utp_pkg::DIV_SYNC_SLOW;
			utp_pkg::UTP_ASYNC_SYS: div_top = smr.mult ? utp_pkg::DIV_SYS_FAST : utp_pkg::DIV_SYS_SLOW;
			default: div_top = smr.mult ? utp_pkg::DIV_BAUD_FAST : utp_pkg::DIV_BAUD_SLOW;
		endcase
		next_div_cnt = div_cnt;
		if (ctrl.mode == utp_pkg::UTP_SYNC || ctrl.mode == utp_pkg::UTP_ASYNC_SYS || baud_en) begin
			next_div_cnt = (div_cnt >= div_top) ? 6'h00 : div_cnt + 6'h01;
		end
	end

	// Pin function; the shifter itself is untouched by the selection
	always_comb begin
		mod_active = smr.mod_en && ctrl.mode != utp_pkg::UTP_SYNC;
		if (!mod_active) begin
			next_pin = uart_tx_signal;
		end else if (smr.ofs) begin
			next_pin = uart_tx_signal | timer_low_byte_waveform;
		end else begin
			next_pin = !(uart_tx_signal | timer_low_byte_waveform);
		end
	end

	// State registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= utp_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= utp_pkg::RESP_OKAY;
			smr <= utp_pkg::utp_smr_s'(utp_pkg::MODE_RST);
			phase <= utp_pkg::PHASE_RST;
			ctrl <= utp_pkg::utp_ctrl_s'(utp_pkg::CTRL_RST);
			acc <= 17'h0;
			div_cnt <= 6'h00;
			pin <= 1'b1;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			smr <= next_smr;
			phase <= next_phase;
			ctrl <= next_ctrl;
			acc <= next_acc;
			div_cnt <= next_div_cnt;
			pin <= next_pin;
		end
	end

	// Checks
	sequence mod_on_s;
		smr.mod_en && ctrl.mode != utp_pkg::UTP_SYNC;
	endsequence
	sequence nor_sel_s;
		!smr.ofs;
	endsequence
	sequence bus_wr_s;
		do_write;
	endsequence

	pin_nor_a: assert property (@(posedge sys_clk) disable iff (rst)
		(mod_on_s and nor_sel_s) |=> pin == !($past(uart_tx_signal) | $past(timer_low_byte_waveform)))
		else $error("pin is not NOR in modulation");
	pin_or_a: assert property (@(posedge sys_clk) disable iff (rst)
		(smr.mod_en && smr.ofs && ctrl.mode != utp_pkg::UTP_SYNC)
		|=> pin == ($past(uart_tx_signal) | $past(timer_low_byte_waveform)))
		else $error("pin is not OR in modulation");
	sync_plain_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl.mode == utp_pkg::UTP_SYNC |=> pin == $past(uart_tx_signal))
		else $error("mode 0 pin is modulated");
	off_plain_a: assert property (@(posedge sys_clk) disable iff (rst)
		!smr.mod_en |=> pin == $past(uart_tx_signal))
		else $error("pin modulated while disabled");
	phase_reset_a: assert property (@(posedge sys_clk)
		$fell(rst) |-> phase == 16'h0000)
		else $error("phase not cleared by reset");
	phase_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		(s_axi_arvalid && !rvalid && rd_idx == utp_pkg::IDX_PHASE)
		|=> rvalid && rdata[15:0] == $past(phase) && rdata[31:16] == 16'h0000)
		else $error("phase readback wrong");
	phase_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		(do_write && wr_idx == utp_pkg::IDX_PHASE && w_strb[1:0] == 2'h3)
		|=> phase == $past(w_data[15:0]) && bvalid)
		else $error("phase write lost");
	phase_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!(do_write && wr_idx == utp_pkg::IDX_PHASE) |=> $stable(phase))
		else $error("phase changed without a write");
	write_resp_a: assert property (@(posedge sys_clk) disable iff (rst)
		bus_wr_s |=> bvalid)
		else $error("write not answered");
	bad_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		(do_write && wr_idx != utp_pkg::IDX_MODE && wr_idx != utp_pkg::IDX_PHASE && wr_idx != utp_pkg::IDX_CTRL
		&& wr_idx != utp_pkg::IDX_STAT) |=> bresp == utp_pkg::RESP_SLVERR && $stable(phase) && $stable(smr))
		else $error("unmapped write not refused");
	rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		smr.rsvd == 3'h0)
		else $error("reserved mode bits set");
	pin_reset_a: assert property (@(posedge sys_clk)
		$fell(rst) |-> pin)
		else $error("pin not idle after reset");

	// Baud timing checks
	baud_step_a: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> acc[15:0] == 16'($past(acc[15:0]) + $past(phase)))
		else $error("accumulator ignores phase");
	baud_div_a: assert property (@(posedge sys_clk) disable iff (rst)
		(bit_tick && (ctrl.mode == utp_pkg::UTP_ASYNC_BAUD || ctrl.mode == utp_pkg::UTP_ASYNC_BAUD_MP))
		|-> div_cnt == (smr.mult ? 6'h0f : 6'h3f))
		else $error("baud divide wrong");
	baud_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ctrl.mode == utp_pkg::UTP_ASYNC_BAUD || ctrl.mode == utp_pkg::UTP_ASYNC_BAUD_MP) && !baud_en |=> $stable(div_cnt))
		else $error("divider moved without baud clock");
	baud_adv_a: assert property (@(posedge sys_clk) disable iff (rst)
		((ctrl.mode == utp_pkg::UTP_ASYNC_BAUD || ctrl.mode == utp_pkg::UTP_ASYNC_BAUD_MP) && baud_en
		&& div_cnt < div_top) |=> div_cnt == $past(div_cnt) + 6'h01)
		else $error("divider missed a baud clock");
	phase_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		phase == 16'h0000 |=> !baud_en)
		else $error("baud clock runs with zero phase");

	// Select timing checks
	sel_next_a: assert property (@(posedge sys_clk) disable iff (rst)
		(mod_active && $changed(smr.ofs)) |=> pin == ($past(smr.ofs)
		? ($past(uart_tx_signal) | $past(timer_low_byte_waveform))
		: !($past(uart_tx_signal) | $past(timer_low_byte_waveform))))
		else $error("select change not seen on next clock");
	shift_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		(($changed(smr.mod_en) || $changed(smr.ofs)) && $stable(ctrl) && $stable(smr.mult)
		&& $past(div_cnt) < div_top) |-> div_cnt >= $past(div_cnt))
		else $error("pin function change disturbed bit timing");
endmodule : utp_txd_mod

// file: verif/utp_line_rx.sv
`timescale 1ns/1ns
// Far-side line receiver; counts falls of the pin
module utp_line_rx (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic line,
	output logic [15:0] falls
);
	logic last;
	logic [15:0] next_falls;
	// Next count on each high-to-low step
	always_comb begin
		next_falls = falls + {15'h0, last & ~line};
	end
	// Count and previous level
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			falls <= 16'h0;
			last <= 1'b1;
		end else begin
			falls <= next_falls;
			last <= line;
		end
	end
endmodule : utp_line_rx

// file: verif/test_uart0_txd_pwm_and_baud_phase.sv
`timescale 1ns/1ns
module test_uart0_txd_pwm_and_baud_phase;
	logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, tx, tm;
	logic awready, wready, bvalid, arready, rvalid, bit_tick, pin;
	logic [9:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] wstrb;
	logic [1:0] wr_resp;
	logic [15:0] falls;
	int num_errors, comparisons, gap;
	// Rows: ctrl, mode byte, tx, timer, expected pin
	logic [23:0] rows [7] = '{24'h1_80_0_0_1, 24'h1_80_1_0_0, 24'h3_c0_0_1_1, 24'h2_c0_0_0_0,
		24'h0_c0_0_1_0, 24'h1_40_0_1_0, 24'h1_00_1_1_1};

	utp_txd_mod dut_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .uart_tx_signal(tx),
		.timer_low_byte_waveform(tm), .bit_tick(bit_tick), .uart0_transmit_pin(pin));
	utp_line_rx rx_u (.sys_clk(sys_clk), .rst(rst), .line(pin), .falls(falls));

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task wrap_up;
		$display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task expired;
		chk(32'h0, 32'h1);
		wrap_up();
	endtask : expired

	task automatic wr_t(input logic [9:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				wr_resp = bresp;
				break;
			end
		end
		bready <= 1'b0;
		if (n == 50) expired();
	endtask : wr_t

	task automatic rd_t(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
		if (n == 50) expired();
	endtask : rd_t

	// Clocks from one bit period pulse to the next
	task automatic tick_gap(output int g);
		int n;
		g = 1;
		for (n = 0; n < 300 && !bit_tick; n++) @(posedge sys_clk);
		if (!bit_tick) expired();
		@(posedge sys_clk);
		for (n = 0; n < 300 && !bit_tick; n++) begin
			@(posedge sys_clk);
			g++;
		end
		if (!bit_tick) expired();
	endtask : tick_gap

	// Main sequence
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready, tx, tm} = 8'h82;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rd_t(10'h24, rd, rs);
		chk(rd, 32'h0);
		chk({31'h0, pin}, 32'h1);
		$display("reset test done");
		wr_t(10'h24, 32'hffff_a5c3);
		chk({30'h0, wr_resp}, {30'h0, utp_pkg::RESP_OKAY});
		rd_t(10'h24, rd, rs);
		chk(rd, 32'h0000_a5c3);
		rd_t(10'h3c, rd, rs);
		chk({30'h0, rs}, {30'h0, utp_pkg::RESP_SLVERR});
		chk(rd, 32'h0);
		wr_t(10'h3c, 32'h1);
		chk({30'h0, wr_resp}, {30'h0, utp_pkg::RESP_SLVERR});
		wr_t(10'h20, 32'hff);
		rd_t(10'h20, rd, rs);
		chk(rd, 32'h0000_00c7);
		$display("register test done");
		foreach (rows[i]) begin
			wr_t(10'h34, {28'h0, rows[i][23:20]});
			wr_t(10'h20, {24'h0, rows[i][19:12]});
			tx <= rows[i][8];
			tm <= rows[i][4];
			repeat (3) @(posedge sys_clk);
			chk({31'h0, pin}, {31'h0, rows[i][0]});
		end
		chk({31'h0, falls != 16'h0}, 32'h1);
		wr_t(10'h20, 32'h80);
		{tx, tm} <= 2'b00;
		repeat (2) @(posedge sys_clk);
		chk({31'h0, pin}, 32'h1);
		wr_t(10'h20, 32'hc0);
		@(posedge sys_clk);
		chk({31'h0, pin}, 32'h0);
		rd_t(10'h38, rd, rs);
		chk({30'h0, rd[1:0]}, 32'h2);
		$display("pin function test done");
		wr_t(10'h34, 32'h0);
		tick_gap(gap);
		chk(gap, 32'd12);
		wr_t(10'h34, 32'h4);
		tick_gap(gap);
		chk(gap, 32'd4);
		wr_t(10'h34, 32'h2);
		wr_t(10'h20, 32'h0);
		tick_gap(gap);
		chk(gap, 32'd64);
		wr_t(10'h20, 32'h2);
		tick_gap(gap);
		chk(gap, 32'd32);
		wr_t(10'h34, 32'h1);
		wr_t(10'h24, 32'h8000);
		tick_gap(gap);
		chk(gap, 32'd32);
		wr_t(10'h20, 32'h0);
		tick_gap(gap);
		chk(gap, 32'd128);
		$display("bit timing test done");
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd_t(10'h24, rd, rs);
		chk(rd, 32'h0);
		rd_t(10'h20, rd, rs);
		chk(rd, 32'h0);
		$display("second reset test done");
		wrap_up();
	end
endmodule : test_uart0_txd_pwm_and_baud_phase
